// ===== pkg/twg_pkg.sv
// Package: constants and carrier types for the timer waveform generator
// Contract
// - A count write blocks every compare match during the next timer tick.
// - Reset clears both internal compare output latches to zero.
// - Nonzero action field makes compare output replace the port value; direction unchanged.
// - Port override depends only on the action field, not the waveform mode.
// - Action field zero leaves compare output unchanged at the next match.
// - A new action field value governs the first match after the write.
// - Force strobe applies the action at once in non-PWM modes; latches survive mode change.
// - Mode 0 counts up always, never clears on match, wraps ff to 00.
// - Mode 0 sets overflow flag as count becomes zero; counting never clears it.
// - Mode 2 clears the counter on match with compare value A as top.
// - Mode 2 compare A is written directly; below count means run through ff first.
// - Mode 2 sets compare flag A each time the counter reaches top.
// - Mode 2 action one toggles compare output A on every match.
// - Mode 2 sets overflow flag when counter passes from max to zero.
// - Modes 3 and 7 count single slope to top; top is ff or compare A.
// - Fast PWM clears the counter on the tick after it equals top.
// - Fast PWM action two clears on match, sets at bottom; three the reverse.
// - Fast PWM action one toggles A only with top select bit set; B never.
// - Fast PWM sets overflow flag each time the counter reaches top.
// - Fast PWM compare zero gives a spike per period (256 ticks with top ff); max gives constant level.
// - Compare values are double buffered in fast PWM, direct in clear-on-match.
// - An equality sets that unit's compare flag on the next timer tick.
// - A count write wins over any clear or count in the same cycle.
// - Clock select zero stops the counter; count stays readable and writable.
package twg_pkg;
  localparam logic [7:0] TWG_BOTTOM      = 8'h00;
  localparam logic [7:0] TWG_MAX         = 8'hff;
  localparam logic [7:0] TWG_COUNT_RST   = 8'h00;
  localparam logic [7:0] TWG_COMPARE_RST = 8'h00;
  localparam logic [2:0] TWG_CLK_RST     = 3'h0;
  localparam logic [2:0] TWG_CLK_STOP    = 3'h0;
  localparam logic [2:0] TWG_CLK_DIV1    = 3'h1;
  localparam logic [2:0] TWG_CLK_DIV8    = 3'h2;
  localparam logic [2:0] TWG_CLK_DIV64   = 3'h3;
  localparam logic [2:0] TWG_CLK_DIV256  = 3'h4;
  localparam logic [2:0] TWG_CLK_DIV1024 = 3'h5;
  localparam logic [9:0] TWG_PRESCALE_MASK8    = 10'h007;
  localparam logic [9:0] TWG_PRESCALE_MASK64   = 10'h03f;
  localparam logic [9:0] TWG_PRESCALE_MASK256  = 10'h0ff;
  localparam logic [9:0] TWG_PRESCALE_MASK1024 = 10'h3ff;
  localparam logic [1:0] TWG_ACT_NONE    = 2'h0;
  localparam logic [1:0] TWG_ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] TWG_ACT_CLEAR   = 2'h2;
  localparam logic [1:0] TWG_ACT_SET     = 2'h3;
  localparam logic       TWG_OUT_RST     = 1'b0;
  localparam logic       TWG_FLAG_RST    = 1'b0;

  typedef enum logic [2:0]
  {
    TWG_WS_NORMAL   = 3'h0,
    TWG_WS_PC_MAX   = 3'h1,
    TWG_WS_CTC      = 3'h2,
    TWG_WS_FAST_MAX = 3'h3,
    TWG_WS_RSVD4    = 3'h4,
    TWG_WS_PC_CMP   = 3'h5,
    TWG_WS_RSVD6    = 3'h6,
    TWG_WS_FAST_CMP = 3'h7
  } twg_mode_t;

  // Per-unit software control
  typedef struct packed
  {
    logic [1:0] output_action;
    logic       force_compare_strobe;
    logic       compare_write;
    logic [7:0] compare_wdata;
  } twg_unit_ctl_t;

  // Pin-side view of one compare output
  typedef struct packed
  {
    logic pin_out;
    logic pin_oe;
  } twg_pin_t;
endpackage : twg_pkg

// ===== logic/twg_timer.sv
// Timer waveform generator: counter, two compare units, port override
`timescale 1ns/1ns
`default_nettype none
module twg_timer
(
  // Clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  // Configuration
  input  wire logic [2:0]             i_waveform_select,
  input  wire logic [2:0]             i_clock_select_field,
  // Count value access
  input  wire logic                   i_count_write,
  input  wire logic [7:0]             i_count_wdata,
  output logic [7:0]                  o_count_value,
  // Compare units
  input  wire twg_pkg::twg_unit_ctl_t i_unit_a,
  input  wire twg_pkg::twg_unit_ctl_t i_unit_b,
  output logic [7:0]                  o_compare_value_a,
  output logic [7:0]                  o_compare_value_b,
  output logic [7:0]                  o_compare_buffer_a,
  output logic [7:0]                  o_compare_buffer_b,
  // Flags, cleared by writing one
  input  wire logic                   i_overflow_clear,
  input  wire logic                   i_compare_a_clear,
  input  wire logic                   i_compare_b_clear,
  output logic                        o_overflow_flag,
  output logic                        o_compare_flag_a,
  output logic                        o_compare_flag_b,
  // Port pins
  input  wire logic                   i_port_value_a,
  input  wire logic                   i_port_dir_a,
  input  wire logic                   i_port_value_b,
  input  wire logic                   i_port_dir_b,
  output logic                        o_compare_output_a,
  output logic                        o_compare_output_b,
  output twg_pkg::twg_pin_t           o_pin_a,
  output twg_pkg::twg_pin_t           o_pin_b
);

  logic [9:0]  prescale_reg;
  logic        tick;
  logic [7:0]  count_reg;
  logic [7:0]  count_next;
  logic [7:0]  cmp_a_reg;
  logic [7:0]  cmp_b_reg;
  logic [7:0]  buf_a_reg;
  logic [7:0]  buf_b_reg;
  logic        block_reg;
  logic        oc_a_reg;
  logic        oc_b_reg;
  logic        ovf_reg;
  logic        flag_a_reg;
  logic        flag_b_reg;
  logic        fast_pwm;
  logic        non_pwm;
  logic [7:0]  top_value;
  logic        at_top;
  logic        match_a;
  logic        match_b;
  logic        restart;
  logic        overflow_evt;

  // Next state of one compare output for a match or a restart at bottom
  function automatic logic oc_next
  (
    input logic       cur,
    input logic [1:0] act,
    input logic       fast,
    input logic       toggle_ok,
    input logic       match,
    input logic       bottom
  );
    logic v;
    v = cur;
    if (fast)
    begin
      if (bottom && act[1])
        v = ~act[0];
      else if (match && act == twg_pkg::TWG_ACT_CLEAR)
        v = 1'b0;
      else if (match && act == twg_pkg::TWG_ACT_SET)
        v = 1'b1;
      else if (match && act == twg_pkg::TWG_ACT_TOGGLE && toggle_ok)
        v = ~cur;
    end
    else if (match)
    begin
      case (act)
        twg_pkg::TWG_ACT_TOGGLE: v = ~cur;
        twg_pkg::TWG_ACT_CLEAR:  v = 1'b0;
        twg_pkg::TWG_ACT_SET:    v = 1'b1;
        default:                 v = cur;
      endcase
    end
    return v;
  endfunction : oc_next

  // Timer clock enable from the prescaler
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || i_clock_select_field == twg_pkg::TWG_CLK_STOP)
      prescale_reg <= 10'h000;
    else
      prescale_reg <= prescale_reg + 10'h001;
  end

  always_comb
  begin
    case (i_clock_select_field)
      twg_pkg::TWG_CLK_DIV1:    tick = 1'b1;
      twg_pkg::TWG_CLK_DIV8:    tick = (prescale_reg & twg_pkg::TWG_PRESCALE_MASK8) == twg_pkg::TWG_PRESCALE_MASK8;
      twg_pkg::TWG_CLK_DIV64:   tick = (prescale_reg & twg_pkg::TWG_PRESCALE_MASK64) == twg_pkg::TWG_PRESCALE_MASK64;
      twg_pkg::TWG_CLK_DIV256:  tick = (prescale_reg & twg_pkg::TWG_PRESCALE_MASK256) == twg_pkg::TWG_PRESCALE_MASK256;
      twg_pkg::TWG_CLK_DIV1024: tick = prescale_reg == twg_pkg::TWG_PRESCALE_MASK1024;
      // External clock sources are not wired here; stopped timer as well
      default:                  tick = 1'b0;
    endcase
  end

  // Mode decode; phase correct codes count up and wrap like normal mode, with top ff and no force strobe
  assign fast_pwm  = (i_waveform_select == twg_pkg::TWG_WS_FAST_MAX) ||
                     (i_waveform_select == twg_pkg::TWG_WS_FAST_CMP);
  assign non_pwm   = (i_waveform_select == twg_pkg::TWG_WS_NORMAL) ||
                     (i_waveform_select == twg_pkg::TWG_WS_CTC);
  assign top_value = (i_waveform_select == twg_pkg::TWG_WS_CTC ||
                      i_waveform_select == twg_pkg::TWG_WS_FAST_CMP) ? cmp_a_reg : twg_pkg::TWG_MAX;
  assign at_top    = count_reg == top_value;

  // Matches are gated by the timer tick and blocked after a count write
  assign match_a = tick && !block_reg && (count_reg == cmp_a_reg);
  assign match_b = tick && !block_reg && (count_reg == cmp_b_reg);

  // Restart: CLEAR_ON_MATCH_MODE clears on match of A, fast PWM on the tick after top
  assign restart = tick && ((i_waveform_select == twg_pkg::TWG_WS_CTC && match_a) ||
                            (fast_pwm && at_top));

  // Overflow: zero reached from max in normal/CLEAR_ON_MATCH_MODE, top reached in fast PWM
  assign overflow_evt = tick && (fast_pwm ? at_top : (count_reg == twg_pkg::TWG_MAX));

  always_comb
  begin
    count_next = count_reg;
    if (i_count_write)
      count_next = i_count_wdata;
    else if (restart)
      count_next = twg_pkg::TWG_BOTTOM;
    else if (tick)
      count_next = count_reg + 8'h01;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      count_reg <= twg_pkg::TWG_COUNT_RST;
    else
      count_reg <= count_next;
  end

  // Block stays armed until the next timer tick has passed
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      block_reg <= 1'b0;
    else if (i_count_write)
      block_reg <= 1'b1;
    else if (tick)
      block_reg <= 1'b0;
  end

  // Compare buffers: software always lands here
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      buf_a_reg <= twg_pkg::TWG_COMPARE_RST;
      buf_b_reg <= twg_pkg::TWG_COMPARE_RST;
    end
    else
    begin
      if (i_unit_a.compare_write)
        buf_a_reg <= i_unit_a.compare_wdata;
      if (i_unit_b.compare_write)
        buf_b_reg <= i_unit_b.compare_wdata;
    end
  end

  // Active compare registers: direct outside fast PWM, loaded at bottom inside it
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      cmp_a_reg <= twg_pkg::TWG_COMPARE_RST;
      cmp_b_reg <= twg_pkg::TWG_COMPARE_RST;
    end
    else if (!fast_pwm)
    begin
      if (i_unit_a.compare_write)
        cmp_a_reg <= i_unit_a.compare_wdata;
      if (i_unit_b.compare_write)
        cmp_b_reg <= i_unit_b.compare_wdata;
    end
    else if (restart)
    begin
      cmp_a_reg <= buf_a_reg;
      cmp_b_reg <= buf_b_reg;
    end
  end

  // Compare output latches; never touched by mode changes
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      oc_a_reg <= twg_pkg::TWG_OUT_RST;
      oc_b_reg <= twg_pkg::TWG_OUT_RST;
    end
    else
    begin
      // Action field is read live, so a new value rules the next match
      oc_a_reg <= oc_next(oc_a_reg, i_unit_a.output_action, fast_pwm, i_waveform_select[2],
                          match_a || (non_pwm && i_unit_a.force_compare_strobe),
                          fast_pwm && restart);
      oc_b_reg <= oc_next(oc_b_reg, i_unit_b.output_action, fast_pwm, 1'b0,
                          match_b || (non_pwm && i_unit_b.force_compare_strobe),
                          fast_pwm && restart);
    end
  end

  // Flags: hardware set wins over a clear in the same cycle; force never sets them
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ovf_reg    <= twg_pkg::TWG_FLAG_RST;
      flag_a_reg <= twg_pkg::TWG_FLAG_RST;
      flag_b_reg <= twg_pkg::TWG_FLAG_RST;
    end
    else
    begin
      if (overflow_evt)
        ovf_reg <= 1'b1;
      else if (i_overflow_clear)
        ovf_reg <= 1'b0;
      if (match_a)
        flag_a_reg <= 1'b1;
      else if (i_compare_a_clear)
        flag_a_reg <= 1'b0;
      if (match_b)
        flag_b_reg <= 1'b1;
      else if (i_compare_b_clear)
        flag_b_reg <= 1'b0;
    end
  end

  assign o_count_value      = count_reg;
  assign o_compare_value_a  = cmp_a_reg;
  assign o_compare_value_b  = cmp_b_reg;
  assign o_compare_buffer_a = buf_a_reg;
  assign o_compare_buffer_b = buf_b_reg;
  assign o_overflow_flag    = ovf_reg;
  assign o_compare_flag_a   = flag_a_reg;
  assign o_compare_flag_b   = flag_b_reg;
  assign o_compare_output_a = oc_a_reg;
  assign o_compare_output_b = oc_b_reg;

  // Override from the action field alone; direction stays with the port bit
  assign o_pin_a.pin_out = (|i_unit_a.output_action) ? oc_a_reg : i_port_value_a;
  assign o_pin_a.pin_oe  = i_port_dir_a;
  assign o_pin_b.pin_out = (|i_unit_b.output_action) ? oc_b_reg : i_port_value_b;
  assign o_pin_b.pin_oe  = i_port_dir_b;

endmodule : twg_timer
`default_nettype wire

// ===== bench/twg_timer_assertions.sv
// Checker: port-level properties of the timer waveform generator
`timescale 1ns/1ns
`default_nettype none
module twg_timer_checker
(
  // Clock, reset, configuration
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_n,
  input wire logic [2:0]             i_waveform_select,
  input wire logic [2:0]             i_clock_select_field,
  // Count and compare
  input wire logic                   i_count_write,
  input wire logic [7:0]             i_count_wdata,
  input wire logic [7:0]             o_count_value,
  input wire twg_pkg::twg_unit_ctl_t i_unit_a,
  input wire logic [7:0]             o_compare_value_a,
  // Flags and outputs
  input wire logic                   o_overflow_flag,
  input wire logic                   o_compare_flag_a,
  input wire logic                   o_compare_output_a,
  input wire logic                   i_port_value_a,
  input wire twg_pkg::twg_pin_t      o_pin_a
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic run;
  // Undivided tick with no load pending, so each edge is one count step
  assign run = (i_clock_select_field == 3'h1) && !i_count_write;

  AST_PIN_A: assert property (o_pin_a.pin_out == ((i_unit_a.output_action != 2'h0) ? o_compare_output_a : i_port_value_a))
    else $error("pin a source wrong");
  AST_RESET: assert property (disable iff (1'b0) !i_rst_n |=> o_count_value == 8'h00 && !o_compare_output_a && !o_overflow_flag)
    else $error("reset values wrong");
  AST_STOP: assert property (i_clock_select_field == 3'h0 && !i_count_write |=> $stable(o_count_value))
    else $error("stopped count moved");
  AST_WRITE: assert property (i_count_write |=> o_count_value == $past(i_count_wdata))
    else $error("count load lost");
  AST_NORM_INC: assert property (run && i_waveform_select == 3'h0 |=> o_count_value == $past(o_count_value) + 8'h01)
    else $error("normal count step wrong");
  AST_CTC_CLR: assert property (run && i_waveform_select == 3'h2 && o_count_value == o_compare_value_a
    && !$past(i_count_write) |=> o_count_value == 8'h00)
    else $error("match clear missing");
  AST_FLAG_A: assert property (run && o_count_value == o_compare_value_a && !$past(i_count_write) |=> o_compare_flag_a)
    else $error("compare flag a not set");
  AST_FAST_WRAP: assert property (run && i_waveform_select == 3'h3 && o_count_value == 8'hff
    |=> o_count_value == 8'h00 && o_overflow_flag)
    else $error("fast wrap wrong");
  cover property ($rose(o_overflow_flag));
  cover property ($rose(o_compare_flag_a));
  cover property ($changed(o_compare_output_a));
endmodule : twg_timer_checker
bind twg_timer twg_timer_checker twg_timer_checker_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_waveform_select(i_waveform_select), .i_clock_select_field(i_clock_select_field), .i_count_write(i_count_write),
  .i_count_wdata(i_count_wdata), .o_count_value(o_count_value), .i_unit_a(i_unit_a),
  .o_compare_value_a(o_compare_value_a), .o_overflow_flag(o_overflow_flag), .o_compare_flag_a(o_compare_flag_a),
  .o_compare_output_a(o_compare_output_a), .i_port_value_a(i_port_value_a), .o_pin_a(o_pin_a));
`default_nettype wire

// ===== bench/twg_pin_load.sv
// Partner: outside circuitry on a compare pin, with a pull-down
`timescale 1ns/1ns
`default_nettype none
module twg_pin_load
(
  // Pin from the timer
  input  wire twg_pkg::twg_pin_t i_pin,
  // Level on the wire
  output logic                   o_level
);
  // A released pin falls to the pull-down, never keeps a stale value
  assign o_level = i_pin.pin_oe ? i_pin.pin_out : 1'b0;
endmodule : twg_pin_load
`default_nettype wire

// ===== bench/twg_timer_tb.sv
// Testbench: directed scenarios for the timer waveform generator
`timescale 1ns/1ns
`default_nettype none
module twg_timer_tb;
  logic                   clk, rst_n, cw, ovc, cac, pva, pvb, pda, pdb, lvl, ovf, fa, oca, ocb;
  logic [2:0]             md, sel;
  logic [7:0]             cd, cnt, cva, cba, cvb, cbb;
  logic                   fb;
  twg_pkg::twg_unit_ctl_t ua, ub;
  twg_pkg::twg_pin_t      pa, pb;
  int                     n_mismatch, total_checks;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  twg_timer twg_timer_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_waveform_select(md), .i_clock_select_field(sel),
    .i_count_write(cw), .i_count_wdata(cd), .o_count_value(cnt), .i_unit_a(ua), .i_unit_b(ub),
    .o_compare_value_a(cva), .o_compare_value_b(cvb), .o_compare_buffer_a(cba), .o_compare_buffer_b(cbb),
    .i_overflow_clear(ovc), .i_compare_a_clear(cac), .i_compare_b_clear(cac), .o_overflow_flag(ovf),
    .o_compare_flag_a(fa), .o_compare_flag_b(fb), .i_port_value_a(pva), .i_port_dir_a(pda), .i_port_value_b(pvb),
    .i_port_dir_b(pdb), .o_compare_output_a(oca), .o_compare_output_b(ocb), .o_pin_a(pa), .o_pin_b(pb));
  twg_pin_load twg_pin_load_inst (.i_pin(pa), .o_level(lvl));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  task automatic wcnt(input logic [7:0] v);
    cw = 1'b1;
    cd = v;
    tk(1);
    cw = 1'b0;
  endtask : wcnt
  task automatic wcmp(input logic [7:0] v);
    ua.compare_write = 1'b1;
    ua.compare_wdata = v;
    tk(1);
    ua.compare_write = 1'b0;
  endtask : wcmp
  task automatic clr();
    ovc = 1'b1;
    cac = 1'b1;
    tk(1);
    ovc = 1'b0;
    cac = 1'b0;
  endtask : clr
  task automatic t_normal();
    sel = 3'h1;
    wcnt(8'hfe);
    tk(1);
    chk("count", cnt, 8'hff);
    tk(1);
    chk("count", cnt, 8'h00);
    chk("ovf", ovf, 1'b1);
    tk(1);
    chk("ovf", ovf, 1'b1);
  endtask : t_normal
  task automatic t_match();
    wcmp(8'h05);
    ua.output_action = 2'h1;
    clr();
    wcnt(8'h05);
    tk(1);
    chk("flag_a", fa, 1'b0);
    chk("out_a", oca, 1'b0);
    wcnt(8'h03);
    tk(3);
    chk("flag_a", fa, 1'b1);
    chk("out_a", oca, 1'b1);
    ua.output_action = 2'h0;
    clr();
    wcnt(8'h03);
    tk(3);
    chk("out_a", oca, 1'b1);
  endtask : t_match
  task automatic t_ctc();
    md = 3'h2;
    wcmp(8'h03);
    ua.output_action = 2'h1;
    wcnt(8'h00);
    clr();
    tk(2);
    chk("count", cnt, 8'h03);
    tk(1);
    chk("count", cnt, 8'h00);
    chk("flag_a", fa, 1'b1);
    chk("ovf", ovf, 1'b0);
    chk("out_a", oca, 1'b0);
    wcnt(8'h0a);
    wcmp(8'h02);
    tk(1);
    chk("count", cnt, 8'h0c);
  endtask : t_ctc
  task automatic t_fast();
    md = 3'h3;
    ua.output_action = 2'h2;
    wcmp(8'h04);
    chk("buf_a", cba, 8'h04);
    chk("cmp_a", cva, 8'h02);
    wcnt(8'hfe);
    tk(2);
    chk("count", cnt, 8'h00);
    chk("out_a", oca, 1'b1);
    chk("ovf", ovf, 1'b1);
    chk("cmp_a", cva, 8'h04);
    tk(5);
    chk("out_a", oca, 1'b0);
  endtask : t_fast
  task automatic t_force();
    sel = 3'h0;
    md = 3'h0;
    clr();
    ua.output_action = 2'h3;
    ub.output_action = 2'h3;
    ua.force_compare_strobe = 1'b1;
    ub.force_compare_strobe = 1'b1;
    tk(1);
    ua.force_compare_strobe = 1'b0;
    ub.force_compare_strobe = 1'b0;
    chk("out_a", oca, 1'b1);
    chk("pin_b", pb.pin_out, ocb);
    chk("flag_a", fa, 1'b0);
    pda = 1'b0;
    #1;
    chk("level", lvl, 1'b0);
    pda = 1'b1;
    #1;
    chk("level", lvl, 1'b1);
    ua.output_action = 2'h0;
    #1;
    chk("pin_a", pa.pin_out, 1'b0);
    md = 3'h3;
    ua.output_action = 2'h2;
    ua.force_compare_strobe = 1'b1;
    tk(1);
    ua.force_compare_strobe = 1'b0;
    chk("out_a", oca, 1'b1);
    wcnt(8'h40);
    tk(3);
    chk("count", cnt, 8'h40);
  endtask : t_force
  // Fast PWM with top from compare A: A toggles, B has no toggle
  task automatic t_fast_cmp();
    md = 3'h7;
    sel = 3'h1;
    ua.output_action = 2'h1;
    ub.output_action = 2'h1;
    ua.compare_write = 1'b1;
    ua.compare_wdata = 8'h03;
    ub.compare_write = 1'b1;
    ub.compare_wdata = 8'h01;
    cw = 1'b1;
    cd = 8'h04;
    tk(1);
    ua.compare_write = 1'b0;
    ub.compare_write = 1'b0;
    cw = 1'b0;
    chk("buf_b", cbb, 8'h01);
    chk("cmp_b", cvb, 8'h00);
    tk(1);
    chk("count", cnt, 8'h00);
    chk("cmp_b", cvb, 8'h01);
    chk("flag_b", fb, 1'b0);
    tk(2);
    chk("flag_b", fb, 1'b1);
    chk("out_b", ocb, 1'b1);
    chk("pin_b", pb.pin_out, 1'b1);
    tk(2);
    chk("count", cnt, 8'h00);
    chk("out_a", oca, 1'b0);
  endtask : t_fast_cmp
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  initial
  begin
    {rst_n, cw, ovc, cac, pva, pvb, md, sel, cd} = '0;
    {pda, pdb} = 2'b11;
    ua = '0;
    ub = '0;
    n_mismatch = 0;
    total_checks = 0;
    tk(2);
    rst_n = 1'b1;
    chk("count", cnt, 8'h00);
    chk("out_a", oca, 1'b0);
    chk("out_b", ocb, 1'b0);
    t_normal();
    t_match();
    t_ctc();
    t_fast();
    t_force();
    t_fast_cmp();
    summarize();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : twg_timer_tb
`default_nettype wire
